// ==== design/hpf_pkg.sv ====
package hpf_pkg;
    // time base
    localparam int CLK_NS = 20;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int US_W = 24;
    localparam logic [US_W-1:0] US_MAX = 24'hff_ffff;
    localparam int TS_LEN = 4;
    localparam int MSG_MAX = 260;
    ////////////////////////////////////////////////////////////////////////////
    // header codes
    localparam logic [3:0] NIB_MSG = 4'h0;
    localparam logic [7:0] HDR_EXT1 = 8'h11;
    localparam logic [7:0] HDR_EXT2 = 8'h12;
    localparam logic [7:0] HDR_TXACK = 8'ha1;
    localparam logic [15:0] SHORT_MAX = 16'h000f;
    localparam logic [15:0] EXT1_MAX = 16'h00ff;
    // status byte bits
    localparam int ST_CKERR = 0;
    localparam int ST_FMT = 1;
    localparam int ST_TXOK = 5;
    localparam int ST_OWN = 6;
    ////////////////////////////////////////////////////////////////////////////
    // operating modes
    localparam logic [2:0] MODE_VPW = 3'h0;
    localparam logic [2:0] MODE_PWM = 3'h1;
    localparam logic [2:0] MODE_KWP = 3'h2;
    localparam logic [2:0] MODE_CAN = 3'h3;
    localparam logic [2:0] MODE_UART = 3'h4;
    localparam logic [2:0] MODE_LIN = 3'h5;
    localparam logic [2:0] MODE_INV = 3'h6;
    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_TIME = 8'h08;
    localparam logic [7:0] REG_CNT = 8'h0c;
    localparam int CTRL_MODE = 0;
    localparam int CTRL_TS = 4;
    localparam int CTRL_TXCK = 5;
    localparam int CTRL_KEEP = 6;
    localparam int CTRL_FWD = 7;
    localparam logic [7:0] CTRL_RST = 8'h20;
endpackage

// ==== design/hpf_framer.sv ====
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/10ps
// Notes on behaviour
// - 24-bit counter ticks every microsecond
// - counter wraps from all ones to zero
// - timestamps and protocol timing use this counter
// - packets carry everything, up to 260 bytes
// - header: upper nibble type, lower nibble count
// - header type decoded per direction
// - checksum appended on transmit, switchable
// - every transmission gets some acknowledgment
// - transmit status uses receive status bits
// - no transmit status in CAN or PWM
// - uart mode adds separate transmit status report
// - own echo full or header plus status
// - receive: check checksum, status, forward
// - checksum kept per setting, VPW/CAN strip
// - format check results in status byte
// - timestamps switchable, off after reset
// - no timestamp: header, status, message
// - timestamp: four bytes before status
// - receive header nibble zero with count
// - zero status means no errors
// - over fifteen bytes uses extended header
// - extended form one: 0x11 and count
// - extended form two: 0x12, count msb first
module hpf_framer import hpf_pkg::*; #(
    parameter int MSG_N = MSG_MAX
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // host to device stream
    input wire logic [7:0] i_h2d_data,
    input wire logic i_h2d_valid,
    output logic o_h2d_ready,
    // device to host stream
    output logic [7:0] o_d2h_data,
    output logic o_d2h_valid,
    input wire logic i_d2h_ready,
    // network transmit
    output logic [7:0] o_net_tx_data,
    output logic o_net_tx_valid,
    output logic o_net_tx_last,
    input wire logic i_net_tx_ready,
    input wire logic i_net_tx_done,
    input wire logic i_net_tx_ok,
    // network receive
    input wire logic [7:0] i_net_rx_data,
    input wire logic i_net_rx_valid,
    input wire logic i_net_rx_last,
    input wire logic i_net_rx_own,
    input wire logic i_net_rx_fmt_err,
    output logic o_net_rx_ready,
    // time base and mode for protocol engines
    output logic o_us_tick,
    output logic [US_W-1:0] o_us_time,
    output logic [2:0] o_mode
);
    localparam int DIV_W = $clog2(TICK_CYC);
    localparam int IW = $clog2(MSG_N + 1);

    typedef enum logic [4:0] {
        T_HDR = 5'b00001, T_LN1 = 5'b00010, T_LN2 = 5'b00100,
        T_DAT = 5'b01000, T_CK = 5'b10000
    } hpf_tx_type;
    typedef enum logic [2:0] {
        R_COL = 3'b001, R_SND = 3'b010, R_ACK = 3'b100
    } hpf_rx_type;

    ////////////////////////////////////////////////////////////////////////////
    // microsecond time base
    logic [DIV_W-1:0] div_q;
    logic [US_W-1:0] us_q;
    logic tick_q;
    wire div_wrap = (div_q == DIV_W'(TICK_CYC - 1));

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            div_q <= '0;
            us_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_wrap ? '0 : div_q + 1'b1;
            us_q <= div_wrap ? us_q + 1'b1 : us_q;
            tick_q <= div_wrap;
        end
    end
    assign o_us_tick = tick_q;
    assign o_us_time = us_q;

    ////////////////////////////////////////////////////////////////////////////
    // register port
    logic [7:0] ctrl_q;
    logic [31:0] rdata_q;
    logic [7:0] lstat_q;
    logic [15:0] rxcnt_q, txcnt_q;
    logic pend_q;
    hpf_rx_type rs_q, rs_d;
    wire [2:0] mode = ctrl_q[CTRL_MODE +: 3];
    wire ts_en = ctrl_q[CTRL_TS];
    wire ck_en = ctrl_q[CTRL_TXCK];
    wire strip_all = (mode == MODE_VPW) || (mode == MODE_CAN);
    wire keep_ck = ctrl_q[CTRL_KEEP] && !strip_all;
    wire [31:0] rd_mux =
        (i_addr == REG_CTRL) ? {24'h0, ctrl_q} :
        (i_addr == REG_STAT) ? {22'h0, pend_q, rs_q != R_COL, lstat_q} :
        (i_addr == REG_TIME) ? {8'h0, us_q} :
        (i_addr == REG_CNT) ? {rxcnt_q, txcnt_q} : 32'h0;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q <= CTRL_RST;
            rdata_q <= '0;
        end else begin
            if (i_wr && i_addr == REG_CTRL)
                ctrl_q <= i_wdata[7:0];
            rdata_q <= i_rd ? rd_mux : 32'h0;
        end
    end
    assign o_rdata = rdata_q;
    assign o_mode = mode;

    ////////////////////////////////////////////////////////////////////////////
    // host command parser and network transmit
    hpf_tx_type ts_q, ts_d;
    logic [15:0] tcnt_q, tcnt_d;
    logic skip_q, skip_d;
    logic [7:0] tsum_q, tsum_d, txd_q, txd_d;
    logic txv_q, txv_d, txl_q, txl_d, hrdy_q;
    wire take = hrdy_q && i_h2d_valid;
    wire tx_free = !txv_q || i_net_tx_ready;
    wire [7:0] hb = i_h2d_data;
    wire [15:0] len2 = {tcnt_q[15:8], hb};

    always_comb begin
        ts_d = ts_q;
        tcnt_d = tcnt_q;
        skip_d = skip_q;
        tsum_d = tsum_q;
        txv_d = txv_q && !i_net_tx_ready;
        txd_d = txd_q;
        txl_d = txl_q;
        case (ts_q)
            T_HDR: begin
                if (take) begin
                    tsum_d = 8'h00;
                    tcnt_d = {12'h0, hb[3:0]};
                    skip_d = (hb[7:4] != NIB_MSG);
                    if (hb == HDR_EXT1) begin
                        tcnt_d = 16'h0000;
                        ts_d = T_LN2;
                    end else if (hb == HDR_EXT2) begin
                        ts_d = T_LN1;
                    end else if (hb[3:0] != 4'h0) begin
                        ts_d = T_DAT;
                    end
                end
            end
            T_LN1: if (take) begin
                tcnt_d = {hb, 8'h00};
                ts_d = T_LN2;
            end
            T_LN2: if (take) begin
                tcnt_d = len2;
                skip_d = 1'b0;
                ts_d = (len2 == 16'h0000) ? T_HDR : T_DAT;
            end
            T_DAT: if (take) begin
                tcnt_d = tcnt_q - 1'b1;
                if (!skip_q) begin
                    txv_d = 1'b1;
                    txd_d = hb;
                    tsum_d = tsum_q + hb;
                    txl_d = (tcnt_q == 16'h0001) && !ck_en;
                end
                if (tcnt_q == 16'h0001)
                    ts_d = (!skip_q && ck_en) ? T_CK : T_HDR;
            end
            T_CK: if (tx_free) begin
                txv_d = 1'b1;
                txd_d = tsum_q;
                txl_d = 1'b1;
                ts_d = T_HDR;
            end
            default: ts_d = T_HDR;
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ts_q <= T_HDR;
            tcnt_q <= '0;
            skip_q <= 1'b0;
            tsum_q <= '0;
            txv_q <= 1'b0;
            txd_q <= '0;
            txl_q <= 1'b0;
            hrdy_q <= 1'b0;
        end else begin
            ts_q <= ts_d;
            tcnt_q <= tcnt_d;
            skip_q <= skip_d;
            tsum_q <= tsum_d;
            txv_q <= txv_d;
            txd_q <= txd_d;
            txl_q <= txl_d;
            // one byte in flight; the parser stalls the host instead of buffering
            hrdy_q <= !txv_d && (ts_d != T_CK);
        end
    end
    assign o_h2d_ready = hrdy_q;
    assign o_net_tx_data = txd_q;
    assign o_net_tx_valid = txv_q;
    assign o_net_tx_last = txl_q;

    ////////////////////////////////////////////////////////////////////////////
    // receive collection and host report
    logic [7:0] mem [MSG_N];
    logic [IW-1:0] rlen_q;
    logic [7:0] rsum_q, st_q, ackst_q, d2hd_q, d2hd_d;
    logic [15:0] blen_q, pos_q, mlen_q;
    logic [1:0] hl_q;
    logic [US_W-1:0] tsv_q;
    logic rtse_q, rrdy_q, d2hv_q, d2hv_d;
    wire rx_take = rrdy_q && i_net_rx_valid;
    wire rx_end = rx_take && i_net_rx_last;
    wire room = (rlen_q < IW'(MSG_N));
    wire out_free = !d2hv_q || i_d2h_ready;
    // status byte of the frame being closed
    wire ck_bad = (rsum_q != i_net_rx_data);
    wire [7:0] st_new = (8'(i_net_rx_own) << ST_OWN) | (8'(i_net_rx_own) << ST_TXOK)
        | (8'(i_net_rx_fmt_err || !room) << ST_FMT) | (8'(ck_bad) << ST_CKERR);
    wire fwd = !i_net_rx_own || ctrl_q[CTRL_FWD];
    wire [15:0] nbytes = 16'(rlen_q) + 16'(room);
    wire [15:0] mlen_new = !fwd ? 16'h0000 : keep_ck ? nbytes : nbytes - 1'b1;
    wire [15:0] blen_new = mlen_new + (ts_en ? 16'(TS_LEN) : 16'h0000) + 16'h0001;
    wire [1:0] hl_new = (blen_new <= SHORT_MAX) ? 2'd1 :
        (blen_new <= EXT1_MAX) ? 2'd2 : 2'd3;
    // byte selection for the report
    wire [15:0] q = pos_q - 16'(hl_q);
    wire [15:0] r = q - (rtse_q ? 16'(TS_LEN) : 16'h0000);
    wire [31:0] ts32 = {8'h00, tsv_q};
    wire [7:0] ts_b = ts32[8'(31 - 8 * q[1:0]) -: 8];
    wire [7:0] hdr_b =
        (hl_q == 2'd1) ? {NIB_MSG, blen_q[3:0]} :
        (pos_q == 16'h0000) ? ((hl_q == 2'd2) ? HDR_EXT1 : HDR_EXT2) :
        (pos_q == 16'h0001 && hl_q == 2'd3) ? blen_q[15:8] : blen_q[7:0];
    wire [7:0] msg_b = mem[IW'(r - 1'b1)];
    wire [7:0] snd_b = (pos_q < 16'(hl_q)) ? hdr_b :
        (rtse_q && q < 16'(TS_LEN)) ? ts_b :
        (r == 16'h0000) ? st_q : msg_b;
    wire [15:0] last_pos = 16'(hl_q) + blen_q - 1'b1;
    wire ack_set = i_net_tx_done && mode == MODE_UART;
    wire ack_clr = (rs_q == R_ACK) && out_free && pos_q == 16'h0001;

    always_comb begin
        rs_d = rs_q;
        d2hv_d = d2hv_q && !i_d2h_ready;
        d2hd_d = d2hd_q;
        case (rs_q)
            R_COL: begin
                if (rx_end)
                    rs_d = R_SND;
                else if (pend_q && rlen_q == '0 && !rx_take && out_free)
                    rs_d = R_ACK;
            end
            R_SND: if (out_free) begin
                d2hv_d = 1'b1;
                d2hd_d = snd_b;
                if (pos_q == last_pos)
                    rs_d = R_COL;
            end
            R_ACK: if (out_free) begin
                d2hv_d = 1'b1;
                d2hd_d = (pos_q == 16'h0000) ? HDR_TXACK : ackst_q;
                if (pos_q == 16'h0001)
                    rs_d = R_COL;
            end
            default: rs_d = R_COL;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (rx_take && room)
            mem[rlen_q] <= i_net_rx_data;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rs_q <= R_COL;
            rlen_q <= '0;
            rsum_q <= '0;
            st_q <= '0;
            lstat_q <= '0;
            blen_q <= '0;
            mlen_q <= '0;
            hl_q <= 2'd1;
            tsv_q <= '0;
            rtse_q <= 1'b0;
            pos_q <= '0;
            rrdy_q <= 1'b0;
            d2hv_q <= 1'b0;
            d2hd_q <= '0;
            pend_q <= 1'b0;
            ackst_q <= '0;
            rxcnt_q <= '0;
            txcnt_q <= '0;
        end else begin
            rs_q <= rs_d;
            d2hv_q <= d2hv_d;
            d2hd_q <= d2hd_d;
            rrdy_q <= (rs_d == R_COL);
            if (rx_take && !i_net_rx_last) begin
                rlen_q <= room ? rlen_q + 1'b1 : rlen_q;
                rsum_q <= rsum_q + i_net_rx_data;
            end
            if (rx_end) begin
                rlen_q <= '0;
                rsum_q <= '0;
                st_q <= st_new;
                lstat_q <= st_new;
                mlen_q <= mlen_new;
                blen_q <= blen_new;
                hl_q <= hl_new;
                tsv_q <= us_q;
                rtse_q <= ts_en;
                rxcnt_q <= rxcnt_q + 1'b1;
            end
            if (rs_q != R_COL && out_free)
                pos_q <= (rs_d == R_COL) ? 16'h0000 : pos_q + 1'b1;
            // a new done in the clearing cycle keeps the report pending
            pend_q <= ack_set || (pend_q && !ack_clr);
            if (ack_set)
                ackst_q <= 8'(i_net_tx_ok) << ST_TXOK;
            if (i_net_tx_done)
                txcnt_q <= txcnt_q + 1'b1;
        end
    end
    assign o_net_rx_ready = rrdy_q;
    assign o_d2h_valid = d2hv_q;
    assign o_d2h_data = d2hd_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    wire snd_first = rs_q == R_SND && out_free && pos_q == 16'h0000;
    sequence s_frame_end;
        rx_end && !i_net_rx_own && !i_net_rx_fmt_err && !ck_bad && room;
    endsequence
    sequence s_status_out;
        rs_q == R_SND && out_free && pos_q == 16'(hl_q) + (rtse_q ? 16'h0004 : 16'h0000);
    endsequence

    a_us_step: assert property (tick_q |-> us_q == $past(us_q) + 1'b1)
        else $error("microsecond counter did not step");
    a_us_wrap: assert property (tick_q && $past(us_q) == US_MAX |-> us_q == '0)
        else $error("microsecond counter did not wrap");
    a_tick_gap: assert property (tick_q |-> ##50 tick_q)
        else $error("tick period is not one microsecond");
    a_clean_status: assert property (s_frame_end |=> st_q == 8'h00)
        else $error("clean frame reported nonzero status");
    a_status_out: assert property (s_status_out |=> d2hd_q == $past(st_q))
        else $error("status byte not sent after header");
    a_short_hdr: assert property (snd_first && blen_q <= SHORT_MAX |=> d2hd_q[7:4] == NIB_MSG)
        else $error("receive header nibble not zero");
    a_ext_hdr: assert property (snd_first && blen_q > SHORT_MAX
        |=> d2hd_q == HDR_EXT1 || d2hd_q == HDR_EXT2)
        else $error("long report lacks extended header");
    a_tx_cksum: assert property (ts_q == T_CK && tx_free |=> txl_q && txd_q == $past(tsum_q))
        else $error("appended checksum wrong");
    a_uart_ack: assert property (ack_set |-> ##[1:1000] (d2hv_q && d2hd_q == HDR_TXACK))
        else $error("uart mode transmit report missing");
    a_no_can_ack: assert property (mode == MODE_CAN && !pend_q |=> !pend_q)
        else $error("CAN mode raised a transmit report");
    a_strip_ck: assert property (rx_end && strip_all && fwd |=> mlen_q == $past(nbytes) - 1'b1)
        else $error("checksum not stripped");
    a_out_hold: assert property (d2hv_q && !i_d2h_ready |=> d2hv_q && $stable(d2hd_q))
        else $error("report byte changed while stalled");
endmodule // hpf_framer

// ==== testbench/hpf_host_model.sv ====
`timescale 1ns/10ps
module hpf_host_model (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // stream to device
    output logic [7:0] o_h2d_data,
    output logic o_h2d_valid,
    input wire logic i_h2d_ready,
    // stream from device
    input wire logic [7:0] i_d2h_data,
    input wire logic i_d2h_valid,
    output logic o_d2h_ready,
    input wire logic i_stall
);
    logic [7:0] rx_q[$];
    bit h_to = 1'b0;
    initial begin
        o_h2d_data = 8'h00;
        o_h2d_valid = 1'b0;
    end
    // a stalled host is what makes the device hold its bytes
    assign o_d2h_ready = !i_stall;
    always @(posedge i_clk_sys) begin
        if (!i_rst && i_d2h_valid && o_d2h_ready) begin
            rx_q.push_back(i_d2h_data);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // whole packet, header first, one byte every second cycle at most
    task automatic send_pkt(input logic [7:0] p[$]);
        int i;
        int n;
        for (i = 0; i < p.size(); i++) begin
            @(posedge i_clk_sys);
            o_h2d_data <= p[i];
            o_h2d_valid <= 1'b1;
            for (n = 0; n < 300; n++) begin
                @(posedge i_clk_sys);
                if (i_h2d_ready === 1'b1) break;
            end
            if (n == 300) h_to = 1'b1;
            o_h2d_valid <= 1'b0;
            // released line must not keep showing the last byte
            o_h2d_data <= ~p[i];
        end
    endtask
endmodule // hpf_host_model

// ==== testbench/host_packet_framer_timestamp_tb.sv ====
`timescale 1ns/10ps
`define CHK(what, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("CHECK FAILED %s exp %h got %h", what, exp, got); \
        end \
    end
module host_packet_framer_timestamp_tb import hpf_pkg::*;;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic [7:0] i_h2d_data;
    logic i_h2d_valid, o_h2d_ready, o_d2h_valid, i_d2h_ready, d2h_stall;
    logic [7:0] o_d2h_data, o_net_tx_data;
    logic o_net_tx_valid, o_net_tx_last, i_net_tx_ready, o_net_rx_ready, o_us_tick;
    logic i_net_tx_done = 1'b0;
    logic i_net_tx_ok = 1'b0;
    logic [7:0] i_net_rx_data = 8'h00;
    logic i_net_rx_valid = 1'b0;
    logic i_net_rx_last = 1'b0;
    logic i_net_rx_own = 1'b0;
    logic i_net_rx_fmt_err = 1'b0;
    logic [US_W-1:0] o_us_time, cap;
    logic [2:0] o_mode;
    logic [2:0] stall_cnt = 3'h0;
    logic [8:0] tx_q[$];
    int n_errors = 0;
    int checks_done = 0;
    always #10 i_clk_sys = ~i_clk_sys;
    hpf_framer DUT (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_h2d_data, .i_h2d_valid, .o_h2d_ready, .o_d2h_data, .o_d2h_valid, .i_d2h_ready,
        .o_net_tx_data, .o_net_tx_valid, .o_net_tx_last, .i_net_tx_ready, .i_net_tx_done,
        .i_net_tx_ok, .i_net_rx_data, .i_net_rx_valid, .i_net_rx_last, .i_net_rx_own,
        .i_net_rx_fmt_err, .o_net_rx_ready, .o_us_tick, .o_us_time, .o_mode);
    hpf_host_model HOST (.i_clk_sys, .i_rst, .o_h2d_data(i_h2d_data),
        .o_h2d_valid(i_h2d_valid), .i_h2d_ready(o_h2d_ready), .i_d2h_data(o_d2h_data),
        .i_d2h_valid(o_d2h_valid), .o_d2h_ready(i_d2h_ready), .i_stall(d2h_stall));
    // both far sides stall on a fixed pattern so every transfer of more than four bytes sees backpressure
    assign i_net_tx_ready = stall_cnt[1];
    assign d2h_stall = stall_cnt[2];
    always @(posedge i_clk_sys) begin
        stall_cnt <= stall_cnt + 3'h1;
        if (!i_rst && o_net_tx_valid && i_net_tx_ready) tx_q.push_back({o_net_tx_last, o_net_tx_data});
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic timeout;
        n_errors++;
        give_verdict;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        // read data stand for one cycle only; take them mid-cycle where settled
        @(negedge i_clk_sys);
        d = o_rdata;
    endtask
    function automatic logic [7:0] ck(input logic [7:0] f[$]);
        logic [7:0] s;
        s = 8'h00;
        foreach (f[i]) s = s + f[i];
        return s;
    endfunction
    task automatic net_rx(input logic [7:0] p[$], input logic own, input logic fe);
        int n;
        for (int i = 0; i < p.size(); i++) begin
            @(posedge i_clk_sys);
            i_net_rx_data <= p[i];
            i_net_rx_valid <= 1'b1;
            i_net_rx_last <= (i == p.size() - 1);
            i_net_rx_own <= own;
            i_net_rx_fmt_err <= fe;
            for (n = 0; n < 3000; n++) begin
                @(posedge i_clk_sys);
                if (o_net_rx_ready === 1'b1) break;
            end
            if (n == 3000) timeout();
            cap = o_us_time;
            i_net_rx_valid <= 1'b0;
            i_net_rx_last <= 1'b0;
            i_net_rx_data <= ~p[i];
        end
    endtask
    task automatic wait_d2h(input int k);
        int i;
        for (i = 0; i < 3000 && HOST.rx_q.size() < k; i++) @(posedge i_clk_sys);
        if (i == 3000) timeout();
        repeat (40) @(posedge i_clk_sys);
    endtask
    task automatic exp_d2h(input logic [7:0] e[$]);
        wait_d2h(e.size());
        `CHK("d2h count", e.size(), HOST.rx_q.size())
        foreach (e[i]) `CHK("d2h byte", e[i], HOST.rx_q[i])
        HOST.rx_q.delete();
    endtask
    task automatic rx_case(input logic [7:0] c, input logic [7:0] f[$], input logic own,
        input logic fe, input logic [7:0] e[$]);
        reg_wr(REG_CTRL, {24'h0, c});
        f.push_back(ck(f));
        net_rx(f, own, fe);
        exp_d2h(e);
    endtask
    task automatic tx_case(input logic [7:0] c, input logic [7:0] p[$], input logic [8:0] e[$]);
        int i;
        reg_wr(REG_CTRL, {24'h0, c});
        HOST.send_pkt(p);
        if (HOST.h_to) timeout();
        for (i = 0; i < 3000 && tx_q.size() < e.size(); i++) @(posedge i_clk_sys);
        repeat (40) @(posedge i_clk_sys);
        `CHK("tx count", e.size(), tx_q.size())
        foreach (e[i]) `CHK("tx byte", e[i], tx_q[i])
        tx_q.delete();
    endtask
    task automatic pulse_done(input logic ok);
        @(posedge i_clk_sys);
        i_net_tx_done <= 1'b1;
        i_net_tx_ok <= ok;
        @(posedge i_clk_sys);
        i_net_tx_done <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_time;
        logic [31:0] a, b;
        int i, n;
        reg_rd(REG_CTRL, a);
        `CHK("ctrl reset", 32'h20, a)
        reg_rd(8'h10, a);
        `CHK("unmapped", 32'h0, a)
        reg_wr(REG_CTRL, 32'ha5);
        reg_rd(REG_CTRL, a);
        `CHK("ctrl back", 32'ha5, a)
        `CHK("mode out", MODE_LIN, o_mode)
        for (i = 0; i < 200; i++) begin
            @(posedge i_clk_sys);
            if (o_us_tick === 1'b1) break;
        end
        for (n = 1; n < 200; n++) begin
            @(posedge i_clk_sys);
            if (o_us_tick === 1'b1) break;
        end
        `CHK("tick period", 50, n)
        reg_rd(REG_TIME, a);
        repeat (498) @(posedge i_clk_sys);
        reg_rd(REG_TIME, b);
        `CHK("time step", 24'd10, b[23:0] - a[23:0])
        `CHK("time top", 8'h00, b[31:24])
    endtask
    task automatic t_tx;
        tx_case(8'h20, '{8'h52, 8'h01, 8'h05}, '{});
        tx_case(8'h20, '{8'h02, 8'h11, 8'hf2}, '{9'h011, 9'h0f2, 9'h103});
        tx_case(8'h02, '{8'h03, 8'h01, 8'h02, 8'h03}, '{9'h001, 9'h002, 9'h103});
        tx_case(8'h00, '{8'h11, 8'h02, 8'haa, 8'hbb}, '{9'h0aa, 9'h1bb});
        tx_case(8'h00, '{8'h12, 8'h00, 8'h02, 8'hcc, 8'hdd}, '{9'h0cc, 9'h1dd});
    endtask
    task automatic t_rx;
        logic [7:0] f[$];
        rx_case(8'h20, '{8'ha7, 8'hb6, 8'hc5}, 0, 0, '{8'h04, 8'h00, 8'ha7, 8'hb6, 8'hc5});
        f = '{8'ha7, 8'hb6, 8'hc5, 8'h00};
        reg_wr(REG_CTRL, 32'h20);
        net_rx(f, 0, 0);
        exp_d2h('{8'h04, 8'h01, 8'ha7, 8'hb6, 8'hc5});
        rx_case(8'h62, '{8'h01, 8'h02}, 0, 0, '{8'h04, 8'h00, 8'h01, 8'h02, 8'h03});
        rx_case(8'h63, '{8'h01, 8'h02}, 0, 0, '{8'h03, 8'h00, 8'h01, 8'h02});
        rx_case(8'h22, '{8'h01}, 0, 1, '{8'h02, 8'h02, 8'h01});
        rx_case(8'h20, '{8'h32, 8'h89}, 1, 0, '{8'h01, 8'h60});
        rx_case(8'ha0, '{8'h32, 8'h89}, 1, 0, '{8'h03, 8'h60, 8'h32, 8'h89});
    endtask
    task automatic t_long;
        logic [7:0] f[$];
        logic [7:0] e[$];
        e = '{HDR_EXT1, 8'h15, 8'h00};
        for (int i = 0; i < 20; i++) f.push_back(8'h40 + i[7:0]);
        e = {e, f};
        rx_case(8'h20, f, 0, 0, e);
    endtask
    task automatic t_ts;
        logic [31:0] ts;
        reg_wr(REG_CTRL, 32'h30);
        net_rx('{8'h55, 8'h55}, 0, 0);
        wait_d2h(7);
        `CHK("ts count", 7, HOST.rx_q.size())
        `CHK("ts hdr", 8'h06, HOST.rx_q[0])
        ts = {HOST.rx_q[1], HOST.rx_q[2], HOST.rx_q[3], HOST.rx_q[4]};
        `CHK("ts top", 8'h00, ts[31:24])
        // capture may land on either side of a tick edge
        `CHK("ts value", 1'b1, (ts[23:0] - cap) <= 24'd1)
        `CHK("ts status", 8'h00, HOST.rx_q[5])
        `CHK("ts msg", 8'h55, HOST.rx_q[6])
        HOST.rx_q.delete();
        rx_case(8'h20, '{8'h55}, 0, 0, '{8'h02, 8'h00, 8'h55});
    endtask
    task automatic t_ack;
        reg_wr(REG_CTRL, 32'h24);
        pulse_done(1'b1);
        exp_d2h('{HDR_TXACK, 8'h20});
        pulse_done(1'b0);
        exp_d2h('{HDR_TXACK, 8'h00});
        reg_wr(REG_CTRL, 32'h23);
        pulse_done(1'b1);
        exp_d2h('{});
        reg_wr(REG_CTRL, 32'h21);
        pulse_done(1'b1);
        exp_d2h('{});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        t_time();
        t_tx();
        t_rx();
        t_long();
        t_ts();
        t_ack();
        give_verdict();
    end
endmodule // host_packet_framer_timestamp_tb
